// file: verilog/eimc_top.v
// Two edge interval measure counters feeding the acquisition scan stream.
// Holds the shared source synchroniser, edge detection and scan answer.
// Assumes all inputs but the edge sources synchronous to clock; configuration held static while enabled.
// Assumes the scan logic asks with one-cycle pulses and reads one cycle later.
// Limitation: source levels shorter than one clock cycle are lost.
//
// Function
// - Two independent measure counters, numbered one, two
// - Measures period, width or interval
// - Digital inputs 0..7 selectable, either edge
// - Tachometer input selectable, either edge
// - A/D conversion complete selectable as source
// - Counter zero clock and gate selectable
// - Count ticks from start edge to stop
// - Count read via scan channel list entry
`include "eimc_defines.vh"

module eimc_top
(
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // Edge sources
   input wire adc_done,
   input wire tach_in,
   input wire [`EIMC_NUM_DIN-1:0] din,
   input wire gp_clk_in,
   input wire gp_gate_in,
   // Counter one configuration
   input wire mc1_enable,
   input wire [`EIMC_SEL_W-1:0] mc1_start_sel,
   input wire mc1_start_fall,
   input wire [`EIMC_SEL_W-1:0] mc1_stop_sel,
   input wire mc1_stop_fall,
   // Counter two configuration
   input wire mc2_enable,
   input wire [`EIMC_SEL_W-1:0] mc2_start_sel,
   input wire mc2_start_fall,
   input wire [`EIMC_SEL_W-1:0] mc2_stop_sel,
   input wire mc2_stop_fall,
   // Scan stream sampling
   input wire scan_sample,
   input wire scan_chan_sel,
   output reg [`EIMC_CNT_W-1:0] scan_data_q,
   output reg scan_valid_q,
   // Status
   output wire mc1_running,
   output wire mc2_running
);

   wire [`EIMC_NUM_SRC-1:0] raw_src;
   reg [`EIMC_NUM_SRC-1:0] sync1_q;
   reg [`EIMC_NUM_SRC-1:0] sync2_q;
   reg [`EIMC_NUM_SRC-1:0] prev_q;
   wire [`EIMC_NUM_SRC-1:0] rise_pulse;
   wire [`EIMC_NUM_SRC-1:0] fall_pulse;
   wire [`EIMC_CNT_W-1:0] mc1_result;
   wire [`EIMC_CNT_W-1:0] mc2_result;
   wire mc1_valid;
   wire mc2_valid;
   // Edge pulses stay masked until the warm-up count is full
   reg [`EIMC_WARM_W-1:0] warm_q;
   wire edges_live;

   // Source order matches the selector codes, so a code is also a bit index
   assign raw_src[`EIMC_SRC_ADC_DONE] = adc_done;
   assign raw_src[`EIMC_SRC_TACH] = tach_in;
   assign raw_src[`EIMC_SRC_GP_CLK] = gp_clk_in;
   assign raw_src[`EIMC_SRC_GP_GATE] = gp_gate_in;

   // Digital input i sits at code DIN0 plus i
   genvar di;
   generate
      for (di = 0; di < `EIMC_NUM_DIN; di = di + 1)
      begin : g_din
         assign raw_src[`EIMC_SRC_DIN0 + di] = din[di];
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Two-stage synchroniser; nothing but the second stage reads the first
   always @(posedge clock)
   begin
      if (!rst_b)
      begin
         sync1_q <= {`EIMC_NUM_SRC{1'b0}};
         sync2_q <= {`EIMC_NUM_SRC{1'b0}};
      end
      else
      begin
         sync1_q <= raw_src;
         sync2_q <= sync1_q;
      end
   end

   // Third stage holds the previous synchronised level for edge detection
   always @(posedge clock)
   begin
      if (!rst_b)
         prev_q <= {`EIMC_NUM_SRC{1'b0}};
      else
         prev_q <= sync2_q;
   end

   ////////////////////////////////////////////////////////////////////////
   // Warm-up after reset: the stages restart at zero whatever the pins show,
   // so a pin that idles high would look like a rising edge. Edges stay
   // masked until every stage holds a real sample.
   always @(posedge clock)
   begin
      if (!rst_b)
         warm_q <= `EIMC_WARM_ZERO;
      else if (warm_q != `EIMC_WARM_DONE)
         warm_q <= warm_q + `EIMC_WARM_ONE;
   end

   assign edges_live = (warm_q == `EIMC_WARM_DONE);

   ////////////////////////////////////////////////////////////////////////
   // Edge pulses from the synchronised levels
   // Each pulse lasts one cycle and lags its pin by two cycles
   genvar gi;
   generate
      for (gi = 0; gi < `EIMC_NUM_SRC; gi = gi + 1)
      begin : g_edge
         assign rise_pulse[gi] = edges_live & sync2_q[gi] & ~prev_q[gi];
         // Completion is internal and already a pulse: its leading edge fires
         // whatever sense is selected, so a wrong sense bit cannot lose it
         if (gi == `EIMC_SRC_ADC_DONE)
         begin : g_pulse_src
            assign fall_pulse[gi] = edges_live & sync2_q[gi] & ~prev_q[gi];
         end
         else
         begin : g_level_src
            assign fall_pulse[gi] = edges_live & ~sync2_q[gi] & prev_q[gi];
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Measure counters one and two, independent of each other
   // Both see the same pulse bus; only their enables, selectors and sense bits tell them apart
   eimc_meas_chan u_mc1
   (
      // Clock and reset
      .clock(clock),
      .rst_b(rst_b),
      // Configuration
      .enable(mc1_enable),
      .start_sel(mc1_start_sel),
      .start_fall(mc1_start_fall),
      .stop_sel(mc1_stop_sel),
      .stop_fall(mc1_stop_fall),
      // Shared edge pulses
      .rise_pulse(rise_pulse),
      .fall_pulse(fall_pulse),
      // Result
      .result_q(mc1_result),
      .result_valid_q(mc1_valid),
      .running_q(mc1_running)
   );

   eimc_meas_chan u_mc2
   (
      // Clock and reset
      .clock(clock),
      .rst_b(rst_b),
      // Configuration
      .enable(mc2_enable),
      .start_sel(mc2_start_sel),
      .start_fall(mc2_start_fall),
      .stop_sel(mc2_stop_sel),
      .stop_fall(mc2_stop_fall),
      // Shared edge pulses
      .rise_pulse(rise_pulse),
      .fall_pulse(fall_pulse),
      // Result
      .result_q(mc2_result),
      .result_valid_q(mc2_valid),
      .running_q(mc2_running)
   );

   ////////////////////////////////////////////////////////////////////////
   // Scan sampling: latest completed count, zero until a first one exists
   // Latest completed count of one counter, zero until its first stop edge
   function [`EIMC_CNT_W-1:0] pick_result;
      input valid;
      input [`EIMC_CNT_W-1:0] result;
      begin
         if (valid)
            pick_result = result;
         else
            pick_result = `EIMC_CNT_RST;
      end
   endfunction

   // Answer flag follows each sample request by one cycle
   always @(posedge clock)
   begin
      if (!rst_b)
         scan_valid_q <= 1'b0;
      else
         scan_valid_q <= scan_sample;
   end

   // Sampled word stays put between requests, so the scan logic may read it late
   always @(posedge clock)
   begin
      if (!rst_b)
         scan_data_q <= `EIMC_CNT_RST;
      else if (scan_sample)
      begin
         if (scan_chan_sel)
            scan_data_q <= pick_result(mc2_valid, mc2_result);
         else
            scan_data_q <= pick_result(mc1_valid, mc1_result);
      end
   end

endmodule

// file: verilog/eimc_defines.vh
// Constants for the edge interval measure counter pair.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef EIMC_DEFINES_VH
`define EIMC_DEFINES_VH

// Counter widths and source selector layout
`define EIMC_CNT_W 32
`define EIMC_SEL_W 4
`define EIMC_NUM_SRC 12
`define EIMC_NUM_DIN 8

// Source codes for start and stop selectors
`define EIMC_SRC_ADC_DONE 4'h0
`define EIMC_SRC_TACH 4'h1
`define EIMC_SRC_DIN0 4'h2
`define EIMC_SRC_GP_CLK 4'ha
`define EIMC_SRC_GP_GATE 4'hb

// Edge sense codes
`define EIMC_EDGE_RISE 1'b0
`define EIMC_EDGE_FALL 1'b1

// Warm-up count: cycles after reset until all three input stages hold real samples
`define EIMC_WARM_W 2
`define EIMC_WARM_ZERO 2'h0
`define EIMC_WARM_ONE 2'h1
`define EIMC_WARM_DONE 2'h3

// Count values: reset, increment and saturation limit
`define EIMC_CNT_RST 32'h0000_0000
`define EIMC_CNT_ONE 32'h0000_0001
`define EIMC_CNT_MAX 32'hffff_ffff

`endif

// file: verilog/eimc_meas_chan.v
// One measure counter: start and stop edge selection and interval count.
// Assumes its source bus is already synchronised and edge-detected upstream.
`include "eimc_defines.vh"

module eimc_meas_chan
(
   // Clock and reset
   input wire clock,
   input wire rst_b,
   // Configuration
   input wire enable,
   input wire [`EIMC_SEL_W-1:0] start_sel,
   input wire start_fall,
   input wire [`EIMC_SEL_W-1:0] stop_sel,
   input wire stop_fall,
   // Edge pulses of every source, one bit per source
   input wire [`EIMC_NUM_SRC-1:0] rise_pulse,
   input wire [`EIMC_NUM_SRC-1:0] fall_pulse,
   // Result
   output reg [`EIMC_CNT_W-1:0] result_q,
   output reg result_valid_q,
   output reg running_q
);

   reg [`EIMC_CNT_W-1:0] count_q;
   wire start_hit;
   wire stop_hit;

   // Picks one source edge; codes from the source count up never fire
   function pick_edge;
      input [`EIMC_SEL_W-1:0] sel;
      input fall;
      input [`EIMC_NUM_SRC-1:0] rise_v;
      input [`EIMC_NUM_SRC-1:0] fall_v;
      begin
         if (sel < `EIMC_NUM_SRC)
            pick_edge = (fall == `EIMC_EDGE_FALL) ? fall_v[sel] : rise_v[sel];
         else
            pick_edge = 1'b0;
      end
   endfunction

   assign start_hit = pick_edge(start_sel, start_fall, rise_pulse, fall_pulse);
   assign stop_hit = pick_edge(stop_sel, stop_fall, rise_pulse, fall_pulse);

   ////////////////////////////////////////////////////////////////////////
   // Count from start edge to stop edge; result held until the next stop
   always @(posedge clock)
   begin
      if (!rst_b)
      begin
         count_q <= `EIMC_CNT_RST;
         result_q <= `EIMC_CNT_RST;
         result_valid_q <= 1'b0;
         running_q <= 1'b0;
      end
      else if (!enable)
      begin
         count_q <= `EIMC_CNT_RST;
         running_q <= 1'b0;
      end
      else if (running_q)
      begin
         // Stop and start both act on a shared edge: result taken and count restarts, so one source gives a period
         if (stop_hit)
         begin
            result_q <= count_q;
            result_valid_q <= 1'b1;
            running_q <= start_hit && (start_sel != stop_sel || start_fall != stop_fall) ? 1'b1 : start_hit;
            count_q <= `EIMC_CNT_ONE;
         end
         else if (count_q != `EIMC_CNT_MAX)
            count_q <= count_q + `EIMC_CNT_ONE; // saturates rather than wrapping
      end
      else if (start_hit)
      begin
         running_q <= 1'b1;
         count_q <= `EIMC_CNT_ONE;
      end
   end

endmodule

// file: dv/eimc_checker_properties.sv
// Checker for the measure counter pair: scan answers and run flags.
// Sees top-level ports only; bound into every eimc_top.
`include "eimc_defines.vh"
module eimc_checker
(
   // Clock and reset
   input logic clock,
   input logic rst_b,
   // Inputs watched
   input logic [`EIMC_NUM_DIN-1:0] din,
   input logic mc1_enable,
   input logic [`EIMC_SEL_W-1:0] mc1_start_sel,
   input logic mc1_start_fall,
   input logic mc2_enable,
   input logic scan_sample,
   // Outputs watched
   input logic [`EIMC_CNT_W-1:0] scan_data_q,
   input logic scan_valid_q,
   input logic mc1_running,
   input logic mc2_running
);
   timeunit 1ns;
   timeprecision 1ps;
   // One clock domain, synchronous reset masks every check
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);
   a_scan_answer: assert property (scan_sample |=> scan_valid_q)
      else $error("scan sample not answered");
   a_valid_cause: assert property (!scan_sample |=> !scan_valid_q)
      else $error("valid without sample");
   a_result_hold: assert property (!scan_sample |=> $stable(scan_data_q))
      else $error("scan data moved unasked");
   a_idle_one: assert property (!mc1_enable |=> !mc1_running)
      else $error("counter one runs disabled");
   a_idle_two: assert property (!mc2_enable |=> !mc2_running)
      else $error("counter two runs disabled");
   a_run_cause: assert property ($rose(mc1_running) |-> $past(mc1_enable))
      else $error("counter one started disabled");
   a_run_cause_two: assert property ($rose(mc2_running) |-> $past(mc2_enable))
      else $error("counter two started disabled");
   // Three cycles cover the two sync flops and the edge compare
   a_sync_start: assert property (($rose(din[0]) && mc1_start_sel == `EIMC_SRC_DIN0 && !mc1_start_fall)
      ##0 (mc1_enable && !mc1_running)[*3] |=> mc1_running) else $error("start edge latency wrong");
   c_stop: cover property ($fell(mc1_running) && mc1_enable);
   c_two: cover property ($rose(mc2_running));
   c_scan: cover property (scan_sample);
endmodule
bind eimc_top eimc_checker chk_u (.*);

// file: dv/eimc_far_model.sv
// Far side: edge source levels by source code, and the scan logic.
// Tasks are called by the bench at rising edges only.
`include "eimc_defines.vh"
module eimc_far_model
(
   // Clock
   input logic clock,
   // Source levels and scan request
   output logic [`EIMC_NUM_SRC-1:0] src,
   output logic scan_sample,
   output logic scan_chan_sel,
   // Scan answer
   input logic [`EIMC_CNT_W-1:0] scan_data_q,
   input logic scan_valid_q
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quiet lines from time zero
   initial
   begin
      src = '0;
      scan_sample = 1'b0;
      scan_chan_sel = 1'b0;
   end
   // Level change lands on this edge; edges must be held a full cycle
   task automatic drive(input int code, input logic v);
      src[code] <= v;
   endtask
   // One-cycle request, answer read one edge later
   task automatic sample(input logic ch, output logic v, output logic [`EIMC_CNT_W-1:0] d);
      scan_sample <= 1'b1;
      scan_chan_sel <= ch;
      @(posedge clock);
      scan_sample <= 1'b0;
      @(posedge clock);
      v = scan_valid_q;
      d = scan_data_q;
   endtask
endmodule

// file: dv/testbench.sv
// Self-checking bench for the measure counter pair.
// Far model gives sources and scan; bench holds the configuration.
`include "eimc_defines.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [1:2] en, sf, pf;
   logic [3:0] ss [1:2];
   logic [3:0] ps [1:2];
   logic [`EIMC_NUM_SRC-1:0] src;
   logic scan_sample, scan_chan_sel, scan_valid_q, mc1_running, mc2_running;
   logic [`EIMC_CNT_W-1:0] scan_data_q;
   int n_errors = 0;
   int total_checks = 0;
   always #2 clock = ~clock;
   eimc_far_model far_u (.clock(clock), .src(src), .scan_sample(scan_sample), .scan_chan_sel(scan_chan_sel),
      .scan_data_q(scan_data_q), .scan_valid_q(scan_valid_q));
   eimc_top dut_u (.clock(clock), .rst_b(rst_b), .adc_done(src[0]), .tach_in(src[1]), .din(src[9:2]),
      .gp_clk_in(src[10]), .gp_gate_in(src[11]), .mc1_enable(en[1]), .mc1_start_sel(ss[1]),
      .mc1_start_fall(sf[1]), .mc1_stop_sel(ps[1]), .mc1_stop_fall(pf[1]), .mc2_enable(en[2]),
      .mc2_start_sel(ss[2]), .mc2_start_fall(sf[2]), .mc2_stop_sel(ps[2]), .mc2_stop_fall(pf[2]),
      .scan_sample(scan_sample), .scan_chan_sel(scan_chan_sel), .scan_data_q(scan_data_q),
      .scan_valid_q(scan_valid_q), .mc1_running(mc1_running), .mc2_running(mc2_running));
   task automatic check(input logic [`EIMC_CNT_W-1:0] seen, input logic [`EIMC_CNT_W-1:0] want);
      total_checks++;
      if (seen !== want)
      begin
         n_errors++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Start on code a, stop on the next code with opposite sense
   task automatic t_interval(input int n, input int a, input int gap);
      logic v;
      logic [`EIMC_CNT_W-1:0] d;
      en[n] <= 1'b0;
      ss[n] <= a[3:0];
      sf[n] <= a[0];
      ps[n] <= 4'((a + 1) % 12);
      pf[n] <= ~a[0];
      far_u.drive(a, a[0]);
      far_u.drive((a + 1) % 12, ~a[0]);
      repeat (5) @(posedge clock);
      en[n] <= 1'b1;
      @(posedge clock);
      far_u.drive(a, ~a[0]);
      repeat (gap) @(posedge clock);
      check(n == 1 ? mc1_running : mc2_running, 1'b1);
      far_u.drive((a + 1) % 12, a[0]);
      repeat (5) @(posedge clock);
      check(n == 1 ? mc1_running : mc2_running, 1'b0);
      far_u.sample(n == 2, v, d);
      check(v, 1'b1);
      check(d, gap);
   endtask
   // Tach rises every 7 cycles; a later tach fall while disabled changes nothing
   task automatic t_period();
      logic v;
      logic [`EIMC_CNT_W-1:0] d;
      en[2] <= 1'b0;
      ss[2] <= `EIMC_SRC_TACH;
      ps[2] <= `EIMC_SRC_TACH;
      sf[2] <= 1'b0;
      pf[2] <= 1'b0;
      far_u.drive(1, 1'b0);
      repeat (5) @(posedge clock);
      en[2] <= 1'b1;
      repeat (2)
      begin
         far_u.drive(1, 1'b1);
         repeat (3) @(posedge clock);
         far_u.drive(1, 1'b0);
         repeat (4) @(posedge clock);
      end
      far_u.drive(1, 1'b1);
      repeat (5) @(posedge clock);
      check(mc2_running, 1'b1);
      far_u.sample(1'b1, v, d);
      check(d, 7);
      en[2] <= 1'b0;
      far_u.drive(1, 1'b0);
      repeat (8) @(posedge clock);
      check(mc2_running, 1'b0);
      far_u.sample(1'b1, v, d);
      check(d, 7);
   endtask
   // Unused start code 12 never starts a count, whatever the sources do
   task automatic t_dead_code();
      en[1] <= 1'b0;
      ss[1] <= 4'hc;
      ps[1] <= 4'hf;
      repeat (2) @(posedge clock);
      en[1] <= 1'b1;
      for (int c = 0; c < `EIMC_NUM_SRC; c++)
      begin
         far_u.drive(c, ~src[c]);
         repeat (4) @(posedge clock);
      end
      check(mc1_running, 1'b0);
      en[1] <= 1'b0;
   endtask
   // Main sequence: reset, idle reads, every source on both counters
   initial
   begin
      logic v;
      logic [`EIMC_CNT_W-1:0] d;
      en = '0;
      sf = '0;
      pf = '0;
      ss = '{4'h0, 4'h0};
      ps = '{4'h0, 4'h0};
      repeat (3) @(posedge clock);
      rst_b <= 1'b1;
      @(posedge clock);
      far_u.sample(1'b0, v, d);
      check(d, 0);
      for (int n = 1; n <= 2; n++)
         for (int a = 0; a < `EIMC_NUM_SRC; a++)
            t_interval(n, a, 5 + a);
      t_period();
      t_dead_code();
      summarize();
   end
   // Whole run needs about 660 cycles
   initial
   begin
      repeat (5000) @(posedge clock);
      n_errors++;
      summarize();
   end
endmodule
